// >>> common/xbc_pkg.sv
package xbc_pkg;
   localparam int XBC_DW = 24;
   localparam int XBC_AW = 4;
   localparam int XBC_WSW = 5;
   // Register byte addresses
   localparam logic [7:0] XBC_REG_CTRL = 8'h00;
   localparam logic [7:0] XBC_REG_MODE = 8'h04;
   localparam logic [7:0] XBC_REG_ACC = 8'h08;
   localparam logic [7:0] XBC_REG_WDATA = 8'h0c;
   localparam logic [7:0] XBC_REG_RDATA = 8'h10;
   localparam logic [7:0] XBC_REG_STAT = 8'h14;
   // Control register fields
   localparam int XBC_CTRL_WS_LSB = 0;
   localparam int XBC_CTRL_HOLD_BIT = 8;
   localparam int XBC_CTRL_PARK_BIT = 9;
   // Mode register fields
   localparam int XBC_MODE_APD_BIT = 14;
   localparam int XBC_MODE_RAS_BIT = 0;
   localparam int XBC_MODE_RASPOL_BIT = 1;
   // Access register fields
   localparam int XBC_ACC_WR_BIT = 4;
   localparam int XBC_ACC_GO_BIT = 8;
   // Status register fields
   localparam int XBC_STAT_BUSY_BIT = 0;
   localparam int XBC_STAT_OWN_BIT = 1;
   localparam int XBC_STAT_REQ_BIT = 2;
   localparam int XBC_STAT_DONE_BIT = 3;
   // Reset values
   localparam logic [31:0] XBC_CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] XBC_MODE_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      XBC_IDLE = 2'b00,
      XBC_REQ  = 2'b01,
      XBC_CYC  = 2'b10,
      XBC_END  = 2'b11
   } xbc_state_t;
endpackage

// >>> hw/xbc_sync.sv
`timescale 1ns/1ps
module xbc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   input  wire logic [W-1:0] rst_val_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   // Refuse a width the flops cannot hold
   if (W < 1) begin : g_width_chk
      $error("xbc_sync width must be positive");
   end
   // Reset value is a constant at every instance, so reset stays synchronous
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= rst_val_i;
         q_o    <= rst_val_i;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule

// >>> hw/xbc_attr.sv
`timescale 1ns/1ps
module xbc_attr
   import xbc_pkg::*;
(
   input  wire logic [XBC_AW-1:0] sel_i,
   input  wire logic              apd_i,
   input  wire logic              ras_mode_i,
   input  wire logic              ras_pol_i,
   input  wire logic              active_i,
   output logic      [XBC_AW-1:0] attr_o
);
   logic [XBC_AW-1:0] one_hot;
   always_comb begin
      one_hot = '0;
      for (int i = XBC_AW - 1; i >= 0; i--) begin
         if (sel_i[i]) begin
            one_hot = '0;
            one_hot[i] = 1'b1;
         end
      end
      if (apd_i) begin
         attr_o = active_i ? sel_i : '0;
      end else begin
         attr_o = active_i ? one_hot : '0;
      end
      if (ras_mode_i && !ras_pol_i) begin
         attr_o = ~attr_o;
      end
   end
endmodule

// >>> hw/xbc_top.sv
`timescale 1ns/1ps
module xbc_top
   import xbc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [31:0]       dat_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   input  wire logic              stop_wait_i,
   input  wire logic              bus_grant_n_i,
   input  wire logic              transfer_ack_n_i,
   input  wire logic [XBC_DW-1:0] data_in_i,
   output logic      [XBC_DW-1:0] data_out_o,
   output logic                   data_oe_o,
   output logic      [XBC_AW-1:0] addr_attr_lines_o,
   output logic                   addr_attr_oe_o,
   output logic                   read_n_o,
   output logic                   read_oe_o,
   output logic                   write_n_o,
   output logic                   write_oe_o,
   output logic                   bus_request_n_o
);
   xbc_state_t        st_q;
   logic [31:0]       ctrl_q, mode_q;
   logic [XBC_AW-1:0] acc_sel_q;
   logic              acc_wr_q, pend_q, done_q;
   logic [XBC_DW-1:0] wdata_q, rdata_q;
   logic [XBC_WSW-1:0] ws_q;
   logic              own_q, ta_s, bg_s, hold;
   logic [XBC_AW-1:0] attr_c;
   logic              wb_hit;

   // Pins from outside the clock domain pass two flops
   xbc_sync #(.W(2)) u_sync (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .d_i       ({transfer_ack_n_i, bus_grant_n_i}),
      .rst_val_i (2'b11),
      .q_o       ({ta_s, bg_s})
   );

   assign hold   = ctrl_q[XBC_CTRL_HOLD_BIT];
   assign wb_hit = cyc_i && stb_i && !ack_o;

   // Wishbone slave: one wait cycle, ack for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q  <= XBC_CTRL_RST;
         mode_q  <= XBC_MODE_RST;
         wdata_q <= '0;
         acc_sel_q <= '0;
         acc_wr_q  <= 1'b0;
      end else if (wb_hit && we_i && sel_i[0]) begin
         unique case (adr_i)
            XBC_REG_CTRL:  ctrl_q <= dat_i;
            XBC_REG_MODE:  mode_q <= dat_i;
            XBC_REG_WDATA: wdata_q <= dat_i[XBC_DW-1:0];
            XBC_REG_ACC: begin
               if (!pend_q) begin
                  acc_sel_q <= dat_i[XBC_AW-1:0];
                  acc_wr_q  <= dat_i[XBC_ACC_WR_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (wb_hit && !we_i) begin
         unique case (adr_i)
            XBC_REG_CTRL:  dat_o <= ctrl_q;
            XBC_REG_MODE:  dat_o <= mode_q;
            XBC_REG_ACC:   dat_o <= {23'h0, pend_q, 3'h0, acc_wr_q, acc_sel_q};
            XBC_REG_WDATA: dat_o <= {8'h00, wdata_q};
            XBC_REG_RDATA: dat_o <= {8'h00, rdata_q};
            XBC_REG_STAT:  dat_o <= {28'h0, done_q, !bus_request_n_o, own_q, pend_q};
            default:       dat_o <= '0;
         endcase
      end
   end

   // Pending access: set by software go, cleared at cycle end; set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
      end else if (wb_hit && we_i && sel_i[1] && adr_i == XBC_REG_ACC
                   && dat_i[XBC_ACC_GO_BIT]) begin
         pend_q <= 1'b1;
      end else if (st_q == XBC_END) begin
         pend_q <= 1'b0;
      end
   end

   // Done flag: hardware set wins over a status read clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
      end else if (st_q == XBC_END) begin
         done_q <= 1'b1;
      end else if (wb_hit && !we_i && adr_i == XBC_REG_STAT) begin
         done_q <= 1'b0;
      end
   end

   // Ownership follows grant in XBC_IDLE and XBC_REQ only, never taken in stop or wait
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         own_q <= 1'b0;
      end else if (st_q == XBC_IDLE || st_q == XBC_REQ) begin
         own_q <= !bg_s && !stop_wait_i;
      end
   end

   // Cycle state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= XBC_IDLE;
         ws_q <= '0;
      end else begin
         unique case (st_q)
            XBC_IDLE: if (pend_q && !stop_wait_i) st_q <= XBC_REQ;
            XBC_REQ: begin
               if (own_q && !stop_wait_i) begin
                  st_q <= XBC_CYC;
                  ws_q <= ctrl_q[XBC_CTRL_WS_LSB +: XBC_WSW];
               end
            end
            XBC_CYC: begin
               if (ws_q != '0) ws_q <= ws_q - 1'b1;
               if (ws_q == '0 && !ta_s) st_q <= XBC_END;
            end
            XBC_END: st_q <= XBC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else if (st_q == XBC_CYC && ws_q == '0 && !ta_s && !acc_wr_q) begin
         rdata_q <= data_in_i;
      end
   end

   // Bus request from own pending need, hold bit or park bit only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_request_n_o <= 1'b1;
      end else if (stop_wait_i) begin
         if (!hold) bus_request_n_o <= 1'b1;
      end else begin
         bus_request_n_o <= !(hold || (pend_q && st_q != XBC_END)
                              || (ctrl_q[XBC_CTRL_PARK_BIT] && own_q && pend_q));
      end
   end

   xbc_attr u_attr (
      .sel_i      (acc_sel_q),
      .apd_i      (mode_q[XBC_MODE_APD_BIT]),
      .ras_mode_i (mode_q[XBC_MODE_RAS_BIT]),
      .ras_pol_i  (mode_q[XBC_MODE_RASPOL_BIT]),
      .active_i   (st_q == XBC_CYC),
      .attr_o     (attr_c)
   );

   // Pin drivers: all enables drop in reset, stop or wait, or as slave
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_out_o        <= '0;
         data_oe_o         <= 1'b0;
         addr_attr_lines_o <= '0;
         addr_attr_oe_o    <= 1'b0;
         read_n_o          <= 1'b1;
         read_oe_o         <= 1'b0;
         write_n_o         <= 1'b1;
         write_oe_o        <= 1'b0;
      end else begin
         data_out_o <= wdata_q;
         data_oe_o  <= own_q && !stop_wait_i && acc_wr_q && st_q == XBC_REQ
                       || own_q && !stop_wait_i && acc_wr_q && st_q == XBC_CYC
                          && !(ws_q == '0 && !ta_s);
         addr_attr_lines_o <= attr_c;
         addr_attr_oe_o    <= own_q && !stop_wait_i;
         read_n_o  <= !(st_q == XBC_REQ && own_q && !acc_wr_q && !stop_wait_i
                        || st_q == XBC_CYC && !acc_wr_q && !(ws_q == '0 && !ta_s));
         read_oe_o <= own_q && !stop_wait_i;
         write_n_o  <= !(st_q == XBC_REQ && own_q && acc_wr_q && !stop_wait_i
                         || st_q == XBC_CYC && acc_wr_q && !(ws_q == '0 && !ta_s));
         write_oe_o <= own_q && !stop_wait_i;
      end
   end
endmodule

// >>> test/xbc_monitor.sv
`timescale 1ns/1ps
module xbc_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stop_wait_i,
   input wire logic transfer_ack_n_i,
   input wire logic data_oe_o,
   input wire logic addr_attr_oe_o,
   input wire logic read_n_o,
   input wire logic read_oe_o,
   input wire logic write_n_o,
   input wire logic write_oe_o,
   input wire logic bus_request_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rd_oe; !read_n_o |-> read_oe_o; endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("read strobe undriven");
   property p_wr_oe; !write_n_o |-> write_oe_o; endproperty
   a_wr_oe: assert property (p_wr_oe) else $error("write strobe undriven");
   property p_data; data_oe_o |-> write_oe_o; endproperty
   a_data: assert property (p_data) else $error("data driven off write");
   property p_stop;
      stop_wait_i && $past(stop_wait_i)
         |-> !(data_oe_o || addr_attr_oe_o || read_oe_o || write_oe_o);
   endproperty
   a_stop: assert property (p_stop) else $error("pins driven in stop");
   property p_ack_end; $rose(read_n_o) |-> !$past(transfer_ack_n_i, 2); endproperty
   a_ack_end: assert property (p_ack_end) else $error("cycle ended unacked");
   property p_open; transfer_ack_n_i [*5] ##0 !read_n_o |=> !read_n_o; endproperty
   a_open: assert property (p_open) else $error("cycle closed early");
   property p_min; $fell(read_n_o) |=> !read_n_o; endproperty
   a_min: assert property (p_min) else $error("cycle too short");
   property p_rst; $past(rst_i) |-> bus_request_n_o; endproperty
   a_rst: assert property (p_rst) else $error("request out of reset");
   c_rd: cover property ($rose(read_n_o));
   c_wr: cover property ($rose(write_n_o));
   c_slow: cover property (transfer_ack_n_i [*5] ##0 !read_n_o);
endmodule

// >>> test/xbc_mem_model.sv
`timescale 1ns/1ps
module xbc_mem_model
   import xbc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rd_n_i,
   input  wire logic              wr_n_i,
   input  wire logic              req_n_i,
   input  wire logic [3:0]        dly_i,
   input  wire logic [XBC_DW-1:0] bus_i,
   output logic                   ack_n_o,
   output logic                   grant_n_o,
   output logic      [XBC_DW-1:0] drv_o,
   output logic      [XBC_DW-1:0] mem_o
);
   logic [3:0] cnt_q;
   initial begin
      ack_n_o = 1'b1;
      grant_n_o = 1'b1;
      drv_o = 24'h0;
      mem_o = 24'h0;
   end
   // Arbiter grants one clock after the request, no other master
   always @(posedge clk_i) grant_n_o <= req_n_i;
   always @(posedge clk_i) begin
      if (rd_n_i && wr_n_i) begin
         cnt_q <= 4'h0;
         ack_n_o <= 1'b1;
      end else if (cnt_q == dly_i) ack_n_o <= 1'b0;
      else cnt_q <= cnt_q + 4'h1;
   end
   // Undriven bus toggles so a stale value cannot pass
   always @(posedge clk_i) begin
      if (!wr_n_i) mem_o <= bus_i;
      drv_o <= rd_n_i ? ~drv_o : mem_o;
   end
endmodule

// >>> test/xbc_top_tb.sv
`timescale 1ns/1ps
module xbc_top_tb
   import xbc_pkg::*;
;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              we_i = 1'b0;
   logic              cyc_i = 1'b0;
   logic              stb_i = 1'b0;
   logic              stop_wait_i = 1'b0;
   logic [7:0]        adr_i = 8'h00;
   logic [31:0]       dat_i = 32'h0;
   logic [3:0]        sel_i = 4'hf;
   logic [3:0]        dly = 4'h0;
   logic [31:0]       dat_o;
   logic              ack_o, data_oe_o, addr_attr_oe_o, read_n_o, read_oe_o, write_n_o;
   logic              write_oe_o, bus_request_n_o, bus_grant_n_i, transfer_ack_n_i;
   logic [XBC_DW-1:0] data_in_i, data_out_o, drv, mem;
   logic [XBC_AW-1:0] addr_attr_lines_o, attr_q;
   int                run, len, fail_count, comparisons;
   assign data_in_i = data_oe_o ? data_out_o : drv;
   always #50 clk_i = ~clk_i;
   xbc_top i_dut (.clk_i, .rst_i, .adr_i, .dat_i, .we_i, .sel_i, .cyc_i, .stb_i, .dat_o, .ack_o,
      .stop_wait_i, .bus_grant_n_i, .transfer_ack_n_i, .data_in_i, .data_out_o, .data_oe_o,
      .addr_attr_lines_o, .addr_attr_oe_o, .read_n_o, .read_oe_o, .write_n_o, .write_oe_o,
      .bus_request_n_o);
   xbc_mem_model i_mem (.clk_i, .rd_n_i(read_n_o | ~read_oe_o), .wr_n_i(write_n_o | ~write_oe_o),
      .req_n_i(bus_request_n_o), .dly_i(dly), .bus_i(data_in_i), .ack_n_o(transfer_ack_n_i),
      .grant_n_o(bus_grant_n_i), .drv_o(drv), .mem_o(mem));
   always @(posedge clk_i) begin
      if ((!read_n_o && read_oe_o) || (!write_n_o && write_oe_o)) begin
         run <= run + 1;
         attr_q <= addr_attr_lines_o;
      end else if (run != 0) begin
         len <= run;
         run <= 0;
      end
   end
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic timeout;
      fail_count++;
      results;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
         fail_count++;
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) timeout;
   endtask
   task automatic go(input logic w, input logic [3:0] s);
      logic [31:0] r;
      int n;
      n = 0;
      wb(1'b1, XBC_REG_ACC, {23'h0, 1'b1, 3'h0, w, s}, r);
      r = 32'h0;
      while (r[XBC_STAT_DONE_BIT] !== 1'b1 && n < 100) begin
         wb(1'b0, XBC_REG_STAT, 32'h0, r);
         n++;
      end
      if (n >= 100) timeout;
   endtask
   task automatic wait_req(input logic v);
      int n;
      n = 0;
      while (bus_request_n_o !== v && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) timeout;
   endtask
   task automatic t_reset;
      logic [31:0] r;
      wb(1'b0, XBC_REG_CTRL, 32'h0, r);
      chk("ctrl", r, XBC_CTRL_RST);
      chk("request", bus_request_n_o, 32'h1);
      wb(1'b0, XBC_REG_MODE, 32'h0, r);
      chk("mode", r, XBC_MODE_RST);
      wb(1'b0, 8'h18, 32'h0, r);
      chk("unmapped", r, 32'h0);
   endtask
   task automatic t_xfer;
      logic [31:0] r;
      wb(1'b1, XBC_REG_WDATA, 32'h00a5_c3e1, r);
      go(1'b1, 4'h1);
      chk("mem", mem, 32'h00a5_c3e1);
      wb(1'b1, XBC_REG_WDATA, 32'h0, r);
      go(1'b0, 4'h1);
      wb(1'b0, XBC_REG_RDATA, 32'h0, r);
      chk("rdata", r, 32'h00a5_c3e1);
      chk("release", bus_request_n_o, 32'h1);
   endtask
   task automatic t_waits;
      logic [31:0] r;
      wb(1'b1, XBC_REG_CTRL, 32'h0000_000c, r);
      go(1'b0, 4'h1);
      chk("min waits", len >= 12, 32'h1);
      wb(1'b1, XBC_REG_CTRL, 32'h0000_0001, r);
      dly <= 4'h9;
      go(1'b0, 4'h1);
      chk("ack waits", len > 9, 32'h1);
      dly <= 4'h0;
   endtask
   task automatic t_attr;
      logic [31:0] r;
      logic [31:0] mode [4] = '{32'h0, 32'h4000, 32'h1, 32'h3};
      logic [3:0]  want [4] = '{4'h2, 4'h6, 4'hd, 4'h2};
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, XBC_REG_MODE, mode[i], r);
         go(1'b1, 4'h6);
         chk("attr", attr_q, want[i]);
      end
   endtask
   task automatic t_hold;
      logic [31:0] r;
      wb(1'b1, XBC_REG_CTRL, 32'h0000_0101, r);
      wait_req(1'b0);
      chk("hold", bus_request_n_o, 32'h0);
      stop_wait_i <= 1'b1;
      wb(1'b0, XBC_REG_CTRL, 32'h0, r);
      chk("stop hold", bus_request_n_o, 32'h0);
      wb(1'b1, XBC_REG_CTRL, 32'h0000_0001, r);
      wait_req(1'b1);
      chk("stop idle", bus_request_n_o, 32'h1);
      stop_wait_i <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_xfer;
      t_waits;
      t_attr;
      t_hold;
      results;
   end
endmodule
bind xbc_top xbc_monitor i_mon (.clk_i, .rst_i, .stop_wait_i, .transfer_ack_n_i, .data_oe_o,
   .addr_attr_oe_o, .read_n_o, .read_oe_o, .write_n_o, .write_oe_o, .bus_request_n_o);
